// ---- verilog/ahri_defs.svh ----
// Register map, field positions, reset values and timing counts of the host read block
`ifndef AHRI_DEFS_SVH
`define AHRI_DEFS_SVH

// ------------------------------------------------------------
// Register byte addresses
// ------------------------------------------------------------
`define AHRI_CTRL_ADDR 8'h00
`define AHRI_STATUS_ADDR 8'h04
`define AHRI_RESULT_ADDR 8'h08
`define AHRI_IRQ_STATUS_ADDR 8'h0C
`define AHRI_IRQ_MASK_ADDR 8'h10

// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define AHRI_CTRL_PIPE_BIT 0
`define AHRI_STAT_BUSY_BIT 0
`define AHRI_STAT_VALID_BIT 1
`define AHRI_IRQ_DONE_BIT 0
`define AHRI_IRQ_EARLY_BIT 1
`define AHRI_IRQ_WIDTH 2
`define AHRI_CTRL_RESET 1'h0
`define AHRI_IRQ_RESET 2'h0
`define AHRI_PINS_RESET 3'h6
`define AHRI_RESP_OKAY 2'h0
`define AHRI_RESP_SLVERR 2'h2

// ------------------------------------------------------------
// Conversion timing
// ------------------------------------------------------------
`define AHRI_ACLK_NS 100
`define AHRI_CONV_CLOCK_NS 800
`define AHRI_CONV_DIV (`AHRI_CONV_CLOCK_NS / `AHRI_ACLK_NS)
`define AHRI_CONV_CLOCKS 13
`define AHRI_MSB_SEL 12'h800

`endif

// ---- verilog/ahri_pkg.sv ----
// Types shared by the host read block
package ahri_pkg;

    typedef struct packed {
        logic chip_select_n;
        logic read_strobe_n;
        logic high_byte_select;
    } ahri_pins_type;

    typedef enum logic [1:0] {
        AHRI_IDLE = 2'b01,
        AHRI_CONV = 2'b10
    } ahri_sar_state_type;

endpackage

// ---- verilog/ahri_sar.sv ----
// Successive-approximation sequencer paced by the conversion clock
`timescale 1ns/100ps
`include "ahri_defs.svh"

module ahri_sar (
    input logic aclk,
    input logic aresetn,
    input logic start,
    input logic comparator,
    output logic busy,
    output logic done,
    output logic [11:0] trial,
    output logic [11:0] result,
    output logic [11:0] resolved
);

    ahri_pkg::ahri_sar_state_type state;
    logic [3:0] div_cnt;
    logic [3:0] clk_cnt;
    logic [11:0] bit_sel;
    logic tick;
    logic last_clock;
    logic [11:0] next_result;

    assign busy = (state == ahri_pkg::AHRI_CONV);
    assign tick = (div_cnt == 4'(`AHRI_CONV_DIV - 1));
    assign last_clock = (clk_cnt == 4'(`AHRI_CONV_CLOCKS - 1));
    assign next_result = comparator ? (result | bit_sel) : result;

    // ------------------------------------------------------------
    // One bit per conversion clock, MSB first, done on the 13th
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ahri_pkg::AHRI_IDLE;
            div_cnt <= 4'h0;
            clk_cnt <= 4'h0;
            bit_sel <= 12'h000;
            trial <= 12'h000;
            result <= 12'h000;
            resolved <= 12'h000;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                state <= ahri_pkg::AHRI_CONV;
                div_cnt <= 4'h0;
                clk_cnt <= 4'h0;
                bit_sel <= `AHRI_MSB_SEL;
                trial <= `AHRI_MSB_SEL;
                result <= 12'h000;
                resolved <= 12'h000;
            end else begin
                case (state)
                    ahri_pkg::AHRI_CONV: begin
                        div_cnt <= tick ? 4'h0 : div_cnt + 4'h1;
                        if (tick) begin
                            clk_cnt <= clk_cnt + 4'h1;
                            if (last_clock) begin
                                state <= ahri_pkg::AHRI_IDLE;
                                done <= 1'b1;
                            end else begin
                                result <= next_result;
                                resolved <= resolved | bit_sel;
                                bit_sel <= bit_sel >> 1;
                                trial <= next_result | (bit_sel >> 1);
                            end
                        end
                    end
                    ahri_pkg::AHRI_IDLE: begin
                        div_cnt <= 4'h0;
                    end
                    default: begin
                        state <= ahri_pkg::AHRI_IDLE;
                    end
                endcase
            end
        end
    end

    default clocking sar_cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_start_clears_result: assert property (start |=> busy && result == 12'h000 && resolved == 12'h000)
        else $error("conversion start did not clear the working result");
    a_done_last_clock: assert property ($rose(done) |-> $past(clk_cnt) == 4'(`AHRI_CONV_CLOCKS - 1) && !busy)
        else $error("conversion ended on the wrong conversion clock");

endmodule

// ---- verilog/ahri_host_read.sv ----
// Host read interface of a 12-bit successive-approximation converter with AXI4-Lite registers
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "ahri_defs.svh"

// Functional notes
// - In stall style a low read with high byte select low starts a conversion and busy goes low.
// - During a stall conversion the outputs show the previous result.
// - At the end of conversion the latch is updated first, then busy rises with the new result.
// - Byte-wide stall reads use the low eight outputs; the first read starts the conversion.
// - A read with high byte select high puts the top four bits on the low nibble and starts nothing.
// - The top four bits also appear on outputs 11 to 8 during every read.
// - In pipelined style each low-select read starts a conversion and returns the previous result.
// - A later pipelined read returns the fresh result and starts the next conversion.
// - A pipelined read before 13 conversion clocks have passed flags the unresolved bits as invalid.
// - Pipelined byte reads: start, then high nibble, then low byte that starts the next one.
// - High byte select steers the low eight outputs between low byte and top nibble.
// - Results are right justified with the LSB on output 0.
module ahri_host_read (
    input logic aclk,
    input logic aresetn,
    input logic [7:0] awaddr,
    input logic awvalid,
    output logic awready,
    input logic [31:0] wdata,
    input logic [3:0] wstrb,
    input logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input logic bready,
    input logic [7:0] araddr,
    input logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input logic rready,
    input logic chip_select_n,
    input logic read_strobe_n,
    input logic high_byte_select,
    input logic comparator,
    output logic [11:0] dac_code,
    output logic busy_n,
    output logic [11:0] result_outputs,
    output logic result_outputs_oe,
    output logic [11:0] result_invalid,
    output logic irq
);

    // Top nibble is always on 11..8; select picks the low byte or the nibble for 7..0
    function automatic logic [11:0] ahri_place(input logic [11:0] value, input logic high_sel);
        ahri_place = high_sel ? {value[11:8], 4'h0, value[11:8]} : value;
    endfunction

    ahri_pkg::ahri_pins_type pins_raw;
    ahri_pkg::ahri_pins_type pins_meta;
    ahri_pkg::ahri_pins_type pins_sync;
    logic access;
    logic access_prev;
    logic access_start;
    logic hbs;
    logic pipelined;
    logic start_conv;
    logic early_read;
    logic sar_busy;
    logic sar_done;
    logic [11:0] sar_result;
    logic [11:0] sar_resolved;
    logic settle;
    logic latch_valid;
    logic [11:0] result_latch;
    logic early_hold;
    logic [11:0] early_word;
    logic [11:0] early_mask;
    logic [`AHRI_IRQ_WIDTH-1:0] irq_status;
    logic [`AHRI_IRQ_WIDTH-1:0] irq_mask;
    logic [`AHRI_IRQ_WIDTH-1:0] irq_set;
    logic [`AHRI_IRQ_WIDTH-1:0] irq_clr;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire;
    logic wr_ctrl;
    logic wr_irq_status;
    logic wr_irq_mask;
    logic wr_known;
    logic rd_known;
    logic [31:0] rd_word;

    // ------------------------------------------------------------
    // Pin synchronisers and access decode
    // ------------------------------------------------------------
    assign pins_raw = '{chip_select_n, read_strobe_n, high_byte_select};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pins_meta <= `AHRI_PINS_RESET;
            pins_sync <= `AHRI_PINS_RESET;
            access_prev <= 1'b0;
        end else begin
            pins_meta <= pins_raw;
            pins_sync <= pins_meta;
            access_prev <= access;
        end
    end

    assign access = !pins_sync.chip_select_n && !pins_sync.read_strobe_n;
    assign hbs = pins_sync.high_byte_select;
    assign access_start = access && !access_prev;
    assign start_conv = access_start && !hbs && (pipelined || busy_n);
    assign early_read = access_start && pipelined && sar_busy;
    assign result_outputs_oe = access;
    assign busy_n = !(sar_busy || sar_done || settle);

    ahri_sar u_sar (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(start_conv),
        .comparator(comparator),
        .busy(sar_busy),
        .done(sar_done),
        .trial(dac_code),
        .result(sar_result),
        .resolved(sar_resolved)
    );

    // ------------------------------------------------------------
    // Output latch and data drivers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result_latch <= 12'h000;
            latch_valid <= 1'b0;
            settle <= 1'b0;
            early_hold <= 1'b0;
            early_word <= 12'h000;
            early_mask <= 12'h000;
            result_outputs <= 12'h000;
            result_invalid <= 12'h000;
        end else begin
            settle <= sar_done;
            if (sar_done) begin
                result_latch <= sar_result;
                latch_valid <= 1'b1;
            end
            if (early_read) begin
                early_hold <= 1'b1;
                early_word <= sar_result;
                early_mask <= ~sar_resolved;
            end else if (!access) begin
                early_hold <= 1'b0;
            end
            // Previous result stays visible until the latch moves
            result_outputs <= early_hold ? ahri_place(early_word, hbs) : ahri_place(result_latch, hbs);
            result_invalid <= early_hold ? ahri_place(early_mask, hbs) : 12'h000;
        end
    end

    // ------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------
    assign irq_set = {early_read, sar_done};
    assign irq_clr = (wr_irq_status && w_strb[0]) ? w_data[`AHRI_IRQ_WIDTH-1:0] : `AHRI_IRQ_RESET;
    assign irq = |(irq_status & irq_mask);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= `AHRI_IRQ_RESET;
            irq_mask <= `AHRI_IRQ_RESET;
            pipelined <= `AHRI_CTRL_RESET;
        end else begin
            // A new event wins over a clear in the same cycle
            irq_status <= (irq_status & ~irq_clr) | irq_set;
            if (wr_irq_mask && w_strb[0]) begin
                irq_mask <= w_data[`AHRI_IRQ_WIDTH-1:0];
            end
            if (wr_ctrl && w_strb[0]) begin
                pipelined <= w_data[`AHRI_CTRL_PIPE_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    assign awready = !aw_held && !bvalid;
    assign wready = !w_held && !bvalid;
    assign wr_fire = aw_held && w_held && !bvalid;
    assign wr_ctrl = wr_fire && (aw_addr == `AHRI_CTRL_ADDR);
    assign wr_irq_status = wr_fire && (aw_addr == `AHRI_IRQ_STATUS_ADDR);
    assign wr_irq_mask = wr_fire && (aw_addr == `AHRI_IRQ_MASK_ADDR);
    assign wr_known = wr_ctrl || wr_irq_status || wr_irq_mask ||
                      (aw_addr == `AHRI_STATUS_ADDR) || (aw_addr == `AHRI_RESULT_ADDR);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= `AHRI_RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_held <= 1'b1;
                aw_addr <= awaddr;
            end
            if (wvalid && wready) begin
                w_held <= 1'b1;
                w_data <= wdata;
                w_strb <= wstrb;
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wr_known ? `AHRI_RESP_OKAY : `AHRI_RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    assign arready = !rvalid;

    always_comb begin
        rd_word = 32'h0000_0000;
        rd_known = 1'b1;
        if (araddr == `AHRI_CTRL_ADDR) begin
            rd_word[`AHRI_CTRL_PIPE_BIT] = pipelined;
        end else if (araddr == `AHRI_STATUS_ADDR) begin
            rd_word[`AHRI_STAT_BUSY_BIT] = !busy_n;
            rd_word[`AHRI_STAT_VALID_BIT] = latch_valid;
        end else if (araddr == `AHRI_RESULT_ADDR) begin
            rd_word[11:0] = result_latch;
        end else if (araddr == `AHRI_IRQ_STATUS_ADDR) begin
            rd_word[`AHRI_IRQ_WIDTH-1:0] = irq_status;
        end else if (araddr == `AHRI_IRQ_MASK_ADDR) begin
            rd_word[`AHRI_IRQ_WIDTH-1:0] = irq_mask;
        end else begin
            rd_known = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `AHRI_RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= rd_word;
            rresp <= rd_known ? `AHRI_RESP_OKAY : `AHRI_RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking main_cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_start_busy_ack: assert property (start_conv |=> !busy_n)
        else $error("busy did not go low after a conversion start");
    a_hold_prev_result: assert property (sar_busy |=> $stable(result_latch))
        else $error("output latch moved during a conversion");
    a_latch_then_busy: assert property (sar_done && !start_conv |=> result_latch == $past(sar_result) && !busy_n ##1 busy_n)
        else $error("latch and busy release out of order");
    a_high_no_start: assert property (access_start && hbs |-> !start_conv)
        else $error("high byte read started a conversion");
    a_high_nibble_low: assert property (access && hbs && !early_hold |=> result_outputs[7:0] == {4'h0, $past(result_latch[11:8])})
        else $error("high byte read placed wrong bits on the low outputs");
    a_top_nibble_always: assert property (!early_hold |=> result_outputs[11:8] == $past(result_latch[11:8]))
        else $error("top nibble missing from outputs 11 to 8");
    a_pipe_read_starts: assert property (access_start && !hbs && pipelined |-> start_conv)
        else $error("pipelined read did not start a conversion");
    a_early_read_mask: assert property (early_read |=> early_hold && early_mask == ~$past(sar_resolved))
        else $error("early read did not flag the unresolved bits");
    a_low_byte_select: assert property (!hbs && !early_hold |=> result_outputs == $past(result_latch))
        else $error("low select did not present the right justified result");
    a_oe_released: assert property ($past(pins_meta.chip_select_n) || $past(pins_meta.read_strobe_n)
        |-> !result_outputs_oe)
        else $error("data outputs driven outside an access");
    a_busy_rise_new: assert property ($rose(busy_n) |-> result_latch == $past(sar_result, 2))
        else $error("busy released before the latch held the new result");
    a_invalid_only_early: assert property (!early_hold |=> result_invalid == 12'h000)
        else $error("invalid flags shown outside an early read");

endmodule

// ---- dv/ahri_host_model.sv ----
// Host bus master model with the analog comparator that sits behind the converter
`timescale 1ns/100ps

module ahri_host_model (
    input logic aclk,
    input logic [11:0] level,
    input logic [11:0] dac_code,
    input logic busy_n,
    input logic [11:0] result_outputs,
    input logic result_outputs_oe,
    input logic [11:0] result_invalid,
    output ahri_pkg::ahri_pins_type pins,
    output logic comparator
);
    // ----------------------------------------
    // Analog side
    // ----------------------------------------
    assign comparator = level >= dac_code;

    initial pins = 3'h6;

    // A released bus carries no usable value
    function automatic logic [11:0] bus_value();
        return result_outputs_oe === 1'b1 ? result_outputs : 'x;
    endfunction

    // ----------------------------------------
    // Bus cycles
    // ----------------------------------------
    task automatic begin_read(input logic hbs);
        @(posedge aclk);
        pins <= {2'h0, hbs};
    endtask

    // Release, then give the synchronisers time to see it
    task automatic end_read();
        @(posedge aclk);
        pins <= 3'h6;
        repeat (3) @(posedge aclk);
    endtask

    // Ready follows busy, so the cycle is held through the whole conversion
    task automatic stall_read(output logic [11:0] during, output logic [11:0] data, output bit ok);
        int n;
        begin_read(1'b0);
        for (n = 0; n < 20 && busy_n !== 1'b0; n++) begin
            @(posedge aclk);
            #1;
        end
        ok = busy_n === 1'b0;
        during = bus_value();
        for (n = 0; n < 300 && busy_n !== 1'b1; n++) begin
            @(posedge aclk);
            #1;
        end
        ok = ok && busy_n === 1'b1;
        data = bus_value();
        end_read();
    endtask

    task automatic quick_read(input logic hbs, output logic [11:0] data, output logic [11:0] inval);
        begin_read(hbs);
        repeat (4) @(posedge aclk);
        #1;
        data = bus_value();
        inval = result_invalid;
        end_read();
    endtask

    // A whole conversion time between pipelined reads
    task automatic conv_gap();
        repeat (120) @(posedge aclk);
    endtask
endmodule

// ---- dv/tb.sv ----
// Self-checking bench of the host read block driven through its host model
`timescale 1ns/100ps
`include "ahri_defs.svh"

module tb;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [11:0] level, prev, data, inval;
    wire awready, wready, bvalid, arready, rvalid, busy_n, oe, irq, comparator;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [11:0] dac_code, result_outputs, result_invalid;
    ahri_pkg::ahri_pins_type pins;
    int failures = 0, comparisons = 0;
    bit ok;

    // ----------------------------------------
    // Design and host model
    // ----------------------------------------
    ahri_host_read ahri_host_read_i (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .chip_select_n(pins.chip_select_n),
        .read_strobe_n(pins.read_strobe_n), .high_byte_select(pins.high_byte_select),
        .comparator(comparator), .dac_code(dac_code), .busy_n(busy_n), .result_outputs(result_outputs),
        .result_outputs_oe(oe), .result_invalid(result_invalid), .irq(irq)
    );
    ahri_host_model ahri_host_model_i (
        .aclk(aclk), .level(level), .dac_code(dac_code), .busy_n(busy_n), .result_outputs(result_outputs),
        .result_outputs_oe(oe), .result_invalid(result_invalid), .pins(pins), .comparator(comparator)
    );

    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    // ----------------------------------------
    // Checking and bus tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want) begin
            failures++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
        end
    endtask

    task automatic hang(input bit done);
        if (!done) begin
            failures++;
            $display("unexpected at %0t: wait ran out", $time);
            close_out();
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d, failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic axi_write(input logic [7:0] addr, input logic [31:0] d, input logic [1:0] resp = `AHRI_RESP_OKAY);
        int n;
        bit seen;
        @(posedge aclk);
        awaddr <= addr;
        wdata <= d;
        wstrb <= 4'hf;
        {awvalid, wvalid, bready} <= 3'h7;
        seen = 1'b0;
        for (n = 0; n < 50 && !seen; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                check(bresp, resp);
                bready <= 1'b0;
                seen = 1'b1;
            end
        end
        hang(seen);
    endtask

    task automatic axi_read(input logic [7:0] addr, input logic [31:0] want, input logic [1:0] resp = `AHRI_RESP_OKAY);
        int n;
        bit seen;
        @(posedge aclk);
        araddr <= addr;
        {arvalid, rready} <= 2'h3;
        seen = 1'b0;
        for (n = 0; n < 50 && !seen; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                check(rdata, want);
                check(rresp, resp);
                rready <= 1'b0;
                seen = 1'b1;
            end
        end
        hang(seen);
    endtask

    task automatic rd(input logic hbs);
        ahri_host_model_i.quick_read(hbs, data, inval);
    endtask

    task automatic sr();
        ahri_host_model_i.stall_read(prev, data, ok);
        hang(ok);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        axi_read(`AHRI_CTRL_ADDR, 32'h0000_0000);
        axi_read(`AHRI_IRQ_MASK_ADDR, 32'h0000_0000);
        axi_read(`AHRI_IRQ_STATUS_ADDR, 32'h0000_0000);
        axi_read(`AHRI_RESULT_ADDR, 32'h0000_0000);
        axi_read(8'h14, 32'h0000_0000, `AHRI_RESP_SLVERR);
        axi_write(8'h14, 32'h0000_0001, `AHRI_RESP_SLVERR);
        axi_write(`AHRI_STATUS_ADDR, 32'h0000_0003);
        axi_read(`AHRI_STATUS_ADDR, 32'h0000_0000);
        check({busy_n, oe, irq}, 3'h4);
        $display("test reset values done");
    endtask

    task automatic t_stall();
        level <= 12'ha5c;
        sr();
        check(prev, 12'h000);
        check(data, 12'ha5c);
        check(oe, 1'b0);
        level <= 12'h3e7;
        sr();
        check(prev, 12'ha5c);
        check(data, 12'h3e7);
        axi_read(`AHRI_RESULT_ADDR, 32'h0000_03e7);
        axi_read(`AHRI_STATUS_ADDR, 32'h0000_0002);
        axi_read(`AHRI_IRQ_STATUS_ADDR, 32'h0000_0001);
        $display("test stall parallel done");
    endtask

    task automatic t_bytes();
        level <= 12'h5c3;
        sr();
        check(data, 12'h5c3);
        rd(1'b1);
        check(data, 12'h505);
        check(busy_n, 1'b1);
        $display("test stall bytes done");
    endtask

    task automatic t_pipe();
        axi_write(`AHRI_CTRL_ADDR, 32'h0000_0001);
        level <= 12'h123;
        rd(1'b0);
        check(data, 12'h5c3);
        ahri_host_model_i.conv_gap();
        level <= 12'hfed;
        rd(1'b0);
        check(data, 12'h123);
        check(inval, 12'h000);
        ahri_host_model_i.conv_gap();
        rd(1'b1);
        check(data, 12'hf0f);
        check(busy_n, 1'b1);
        level <= 12'h0a9;
        rd(1'b0);
        check(data, 12'hfed);
        ahri_host_model_i.conv_gap();
        $display("test pipelined reads done");
    endtask

    task automatic t_early();
        axi_write(`AHRI_IRQ_STATUS_ADDR, 32'h0000_0003);
        axi_write(`AHRI_IRQ_MASK_ADDR, 32'h0000_0002);
        check(irq, 1'b0);
        level <= 12'hfff;
        rd(1'b0);
        check(data, 12'h0a9);
        repeat (40) @(posedge aclk);
        rd(1'b0);
        check({inval[11], inval[0]}, 2'h1);
        check(data ^ inval, 12'hfff);
        check(irq, 1'b1);
        axi_read(`AHRI_IRQ_STATUS_ADDR, 32'h0000_0002);
        axi_write(`AHRI_IRQ_STATUS_ADDR, 32'h0000_0002);
        check(irq, 1'b0);
        ahri_host_model_i.conv_gap();
        axi_read(`AHRI_IRQ_STATUS_ADDR, 32'h0000_0001);
        check(irq, 1'b0);
        axi_write(`AHRI_IRQ_MASK_ADDR, 32'h0000_0003);
        check(irq, 1'b1);
        axi_write(`AHRI_CTRL_ADDR, 32'h0000_0000);
        $display("test early read done");
    endtask

    // ----------------------------------------
    // Run
    // ----------------------------------------
    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata, wstrb, level} = '0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_stall();
        t_bytes();
        t_pipe();
        t_early();
        close_out();
    end
endmodule
